// ==== ext_irq_pkg.sv ====
// Package with register map, field layout and types of the external interrupt sense block
package ext_irq_pkg;

  localparam logic [7:0] SENSE_CONTROL_ADDR  = 8'h00;
  localparam logic [7:0] IRQ_MASK_ADDR       = 8'h01;
  localparam logic [7:0] CPU_FLAGS_ADDR      = 8'h02;
  localparam logic [7:0] PIN_STATUS_ADDR     = 8'h03;

  localparam logic [7:0] SENSE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] IRQ_MASK_RESET      = 8'h00;
  localparam logic [7:0] CPU_FLAGS_RESET     = 8'h00;

  localparam int PIN_A_SENSE_LSB  = 0;
  localparam int PIN_B_SENSE_LSB  = 2;
  localparam int MASK_A_BIT       = 0;
  localparam int MASK_B_BIT       = 1;
  localparam int GLOBAL_IRQ_BIT   = 7;
  localparam int SENSE_FIELD_MASK = 8'h0f;

  typedef enum logic [1:0]
  {
    SENSE_LOW_LEVEL = 2'b00,
    SENSE_ANY_CHANGE = 2'b01,
    SENSE_FALLING = 2'b10,
    SENSE_RISING = 2'b11
  } sense_mode_type;

  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       write;
    logic       read;
  } reg_req_type;

endpackage : ext_irq_pkg

// ==== pin_sense.sv ====
// One pin's sampler, edge detector and trigger select
`timescale 1ns/1ps

module pin_sense
(
  input  wire logic                       clk_sys,
  input  wire logic                       rst_b,
  input  wire logic                       pinLevel,
  input  wire ext_irq_pkg::sense_mode_type mode,
  output logic                            trigger,
  output logic                            sampled
);

  logic syncFirst;
  logic syncSecond;
  logic previous;

  wire risingEdge  = syncSecond & ~previous;
  wire fallingEdge = ~syncSecond & previous;
  wire anyChange   = syncSecond ^ previous;

  // Reset state high avoids a false edge on a pin that idles high
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      syncFirst  <= 1'b1;
      syncSecond <= 1'b1;
      previous   <= 1'b1;
    end
    else
    begin
      syncFirst  <= pinLevel;
      syncSecond <= syncFirst;
      previous   <= syncSecond;
    end
  end

  logic next_trigger;

  always_comb
  begin
    case (mode)
      ext_irq_pkg::SENSE_LOW_LEVEL:  next_trigger = ~syncSecond;
      ext_irq_pkg::SENSE_ANY_CHANGE: next_trigger = anyChange;
      ext_irq_pkg::SENSE_FALLING:    next_trigger = fallingEdge;
      ext_irq_pkg::SENSE_RISING:     next_trigger = risingEdge;
      default:                       next_trigger = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      trigger <= 1'b0;
      sampled <= 1'b1;
    end
    else
    begin
      trigger <= next_trigger;
      sampled <= syncSecond;
    end
  end

endmodule : pin_sense

// ==== external_interrupt_sense.sv ====
// Top of the external interrupt sense logic for two pins with register port
//
// Summary of operation
// - Pin B request reaches core only with global enable and pin B mask set.
// - Pin A request reaches core only with global enable and pin A mask set.
// - Control bits 3:2 pick pin B trigger: low, change, falling, rising.
// - Control bits 1:0 pick pin A trigger with the same four codes.
// - Pins are sampled on the clock; edges come from sampled values.
// - Edge or change modes catch every pulse longer than one clock.
`timescale 1ns/1ps

module external_interrupt_sense
(
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       ext_irq_pin_a,
  input  wire logic       ext_irq_pin_b,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWriteData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regReadData,
  output logic            irqRequestA,
  output logic            irqRequestB
);

  // Register map, every register eight bits wide and fully decoded:
  //   sense control  pin B code in bits 3:2, pin A code in bits 1:0
  //   request mask   bit 0 pin A, bit 1 pin B, other bits read as zero
  //   cpu flags      bit 7 global enable, remaining bits only stored
  //   pin status     read only, synchronised levels, pin A in bit 0
  localparam logic [7:0] SENSE_WRITABLE = 8'(ext_irq_pkg::SENSE_FIELD_MASK);
  localparam logic [7:0] MASK_WRITABLE  =
    8'((1 << ext_irq_pkg::MASK_A_BIT) | (1 << ext_irq_pkg::MASK_B_BIT));

  // One address compare shared by every register write strobe
  function automatic logic addrHit
  (
    input ext_irq_pkg::reg_req_type req,
    input logic [7:0]               addr
  );
    addrHit = (req.addr == addr);
  endfunction : addrHit

  // Both pins take their trigger code from a two-bit slice of the control register
  function automatic ext_irq_pkg::sense_mode_type senseField
  (
    input logic [7:0] control,
    input int         lsb
  );
    senseField = ext_irq_pkg::sense_mode_type'(control[lsb +: 2]);
  endfunction : senseField

  // Bits that are not implemented are dropped on write, so they read back as zero
  function automatic logic [7:0] keepWritable
  (
    input logic [7:0] data,
    input logic [7:0] writable
  );
    keepWritable = data & writable;
  endfunction : keepWritable

  // Unmapped addresses read as zero, so software can probe the map safely
  function automatic logic [7:0] readSelect
  (
    input logic [7:0] addr,
    input logic [7:0] sense,
    input logic [7:0] mask,
    input logic [7:0] flags,
    input logic [7:0] status
  );
    case (addr)
      ext_irq_pkg::SENSE_CONTROL_ADDR: readSelect = sense;
      ext_irq_pkg::IRQ_MASK_ADDR:      readSelect = mask;
      ext_irq_pkg::CPU_FLAGS_ADDR:     readSelect = flags;
      ext_irq_pkg::PIN_STATUS_ADDR:    readSelect = status;
      default:                         readSelect = 8'h00;
    endcase
  endfunction : readSelect

  // A request passes only while its own mask bit and the global enable are both set
  function automatic logic gateRequest
  (
    input logic       trigger,
    input logic [7:0] flags,
    input logic [7:0] mask,
    input int         maskBit
  );
    gateRequest = trigger & flags[ext_irq_pkg::GLOBAL_IRQ_BIT] & mask[maskBit];
  endfunction : gateRequest

  ext_irq_pkg::reg_req_type busReq;
  assign busReq = '{addr: regAddr, wdata: regWriteData, write: regWrite, read: regRead};

  logic [7:0] ext_int_sense_control;
  logic [7:0] irqMask;
  logic [7:0] cpu_flags_register;

  wire writeSense = busReq.write && addrHit(busReq, ext_irq_pkg::SENSE_CONTROL_ADDR);
  wire writeMask  = busReq.write && addrHit(busReq, ext_irq_pkg::IRQ_MASK_ADDR);
  wire writeFlags = busReq.write && addrHit(busReq, ext_irq_pkg::CPU_FLAGS_ADDR);

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ext_int_sense_control <= ext_irq_pkg::SENSE_CONTROL_RESET;
    end
    else if (writeSense)
    begin
      ext_int_sense_control <= keepWritable(busReq.wdata, SENSE_WRITABLE);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irqMask <= ext_irq_pkg::IRQ_MASK_RESET;
    end
    else if (writeMask)
    begin
      irqMask <= keepWritable(busReq.wdata, MASK_WRITABLE);
    end
  end

  // All eight flag bits are stored; only the global enable bit acts here
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cpu_flags_register <= ext_irq_pkg::CPU_FLAGS_RESET;
    end
    else if (writeFlags)
    begin
      cpu_flags_register <= busReq.wdata;
    end
  end

  wire ext_irq_pkg::sense_mode_type pin_a_sense_select =
    senseField(ext_int_sense_control, ext_irq_pkg::PIN_A_SENSE_LSB);
  wire ext_irq_pkg::sense_mode_type pin_b_sense_select =
    senseField(ext_int_sense_control, ext_irq_pkg::PIN_B_SENSE_LSB);

  logic triggerA;
  logic triggerB;
  logic sampledA;
  logic sampledB;

  // Each pin has its own sampler, so both may raise a request in the same cycle
  pin_sense senseA
  (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .pinLevel (ext_irq_pin_a),
    .mode     (pin_a_sense_select),
    .trigger  (triggerA),
    .sampled  (sampledA)
  );

  pin_sense senseB
  (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .pinLevel (ext_irq_pin_b),
    .mode     (pin_b_sense_select),
    .trigger  (triggerB),
    .sampled  (sampledB)
  );

  // Gating is combinational on the trigger so a masked edge is dropped, not held
  wire next_irqRequestA = gateRequest(triggerA, cpu_flags_register, irqMask,
    ext_irq_pkg::MASK_A_BIT);
  wire next_irqRequestB = gateRequest(triggerB, cpu_flags_register, irqMask,
    ext_irq_pkg::MASK_B_BIT);

  wire [7:0] pinStatus = {6'h00, sampledB, sampledA};

  // Read data is valid only in the cycle after the strobe, zero otherwise
  wire [7:0] next_regReadData = busReq.read ?
    readSelect(busReq.addr, ext_int_sense_control, irqMask, cpu_flags_register, pinStatus) :
    8'h00;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      regReadData <= 8'h00;
    end
    else
    begin
      regReadData <= next_regReadData;
    end
  end

  // Requests are registered so the core never sees a combinational glitch
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irqRequestA <= 1'b0;
    end
    else
    begin
      irqRequestA <= next_irqRequestA;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irqRequestB <= 1'b0;
    end
    else
    begin
      irqRequestB <= next_irqRequestB;
    end
  end

endmodule : external_interrupt_sense

// ==== ext_irq_sense_sva.sv ====
// Checker of the external interrupt sense ports
`timescale 1ns/1ps
module ext_irq_sense_sva
(
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       ext_irq_pin_a,
  input wire logic       ext_irq_pin_b,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regReadData,
  input wire logic       irqRequestA,
  input wire logic       irqRequestB
);
  logic [7:0] ctl, msk, flg;
  wire logic enA = msk[0] & flg[7];
  wire logic enB = msk[1] & flg[7];
  // Shadow copies of the writable registers
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      {ctl, msk, flg} <= 24'h0;
    else if (regWrite && regAddr == 8'h00)
      ctl <= regWriteData;
    else if (regWrite && regAddr == 8'h01)
      msk <= regWriteData;
    else if (regWrite && regAddr == 8'h02)
      flg <= regWriteData;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_rise_edge_a:
    assert property (irqRequestA && $past(ctl[1:0], 2) == 2'b11
      |-> $past(ext_irq_pin_a, 4) && !$past(ext_irq_pin_a, 5)) else $error("bad rise A");
  a_fall_edge_b:
    assert property (irqRequestB && $past(ctl[3:2], 2) == 2'b10
      |-> !$past(ext_irq_pin_b, 4) && $past(ext_irq_pin_b, 5)) else $error("bad fall B");
  a_change_a:
    assert property (irqRequestA && $past(ctl[1:0], 2) == 2'b01
      |-> $past(ext_irq_pin_a, 4) != $past(ext_irq_pin_a, 5)) else $error("bad change A");
  a_low_level_a:
    assert property ($past(ctl[1:0], 2) == 2'b00 && $past(enA)
      |-> irqRequestA == !$past(ext_irq_pin_a, 4)) else $error("bad level A");
  a_one_cycle_b:
    assert property (irqRequestB && $past(ctl[3]) && $past(ctl[3:2], 2) == $past(ctl[3:2])
      |=> !irqRequestB) else $error("long request B");
  a_gate_a:
    assert property (irqRequestA |-> $past(enA)) else $error("A passed while masked");
  a_gate_b:
    assert property (irqRequestB |-> $past(enB)) else $error("B passed while masked");
  a_pulse_caught_a:
    assert property ($past(ctl[1:0], 2) == 2'b11 && $past(enA) && $past(ext_irq_pin_a, 4)
      && !$past(ext_irq_pin_a, 5) |-> irqRequestA) else $error("missed rise A");
  cover property (irqRequestA);
  cover property (irqRequestB);
  cover property (regRead ##1 regReadData != 8'h00);
endmodule : ext_irq_sense_sva
bind external_interrupt_sense ext_irq_sense_sva ext_irq_sense_sva_i (.*);

// ==== pin_source.sv ====
// Model of the two external sources driving the interrupt pins
`timescale 1ns/1ps
module pin_source
(
  input  wire logic       clk_sys,
  input  wire logic [1:0] want,
  output logic      [1:0] pins
);
  initial pins = 2'b11;
  // Levels move only on clock edges, so a low level is held for whole cycles
  always @(posedge clk_sys)
    pins <= want;
endmodule : pin_source

// ==== tb.sv ====
// Testbench for the external interrupt sense block
`timescale 1ns/1ps
module tb;
  logic       clk_sys = 0, rst_b = 0, regWrite = 0, regRead = 0, irqRequestA, irqRequestB;
  logic [7:0] regAddr = 0, regWriteData = 0, regReadData;
  logic [1:0] want = 2'b11, pins;
  int         failCount = 0, cmpCount = 0, nA, nB, cnt[4] = '{2, 2, 1, 1};
  pin_source pin_source_i (.clk_sys(clk_sys), .want(want), .pins(pins));
  external_interrupt_sense external_interrupt_sense_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .ext_irq_pin_a(pins[0]), .ext_irq_pin_b(pins[1]), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData), .irqRequestA(irqRequestA), .irqRequestB(irqRequestB));
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) nA += int'(irqRequestA);
  always @(posedge clk_sys) nB += int'(irqRequestB);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      failCount++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 chk(regReadData, e);
  endtask : rd
  // Low pulse of n cycles on both pins, requests counted until things settle
  task automatic pulse(input int n);
    #1 nA = 0;
    nB = 0;
    @(posedge clk_sys);
    want <= 2'b00;
    repeat (n) @(posedge clk_sys);
    want <= 2'b11;
    repeat (8) @(posedge clk_sys);
  endtask : pulse
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  initial
  begin
    #20us failCount++;
    results();
  end
  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h00);
    rd(8'h03, 8'h03);
    wr(8'h00, 8'hff);
    rd(8'h00, 8'h0f);
    wr(8'h02, 8'h80);
    wr(8'h01, 8'hff);
    rd(8'h01, 8'h03);
    rd(8'h02, 8'h80);
    $display("Register test done");
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h00, 8'(((3 - m) << 2) | m));
      pulse(2);
      chk(8'(nA), 8'(cnt[m]));
      chk(8'(nB), 8'(cnt[3 - m]));
    end
    $display("Mode test done");
    wr(8'h01, 8'h01);
    pulse(2);
    chk(8'(nA), 8'h01);
    chk(8'(nB), 8'h00);
    wr(8'h02, 8'h00);
    pulse(2);
    chk(8'(nA), 8'h00);
    chk(8'(nB), 8'h00);
    wr(8'h10, 8'h55);
    rd(8'h10, 8'h00);
    $display("Mask test done");
    results();
  end
endmodule : tb
